// >>> dpmb_map.vh
`ifndef DPMB_MAP_VH
`define DPMB_MAP_VH
`define DPMB_AW            12
`define DPMB_DW            9
`define DPMB_SEM_AW        3
`define DPMB_ADDR_MBOX_L   12'hffe
`define DPMB_ADDR_MBOX_R   12'hfff
`define DPMB_CLK_PS        25000
`define DPMB_SETUP_NS      15
`define DPMB_STROBE_NS     25
`define DPMB_HOLD_NS       5
`define DPMB_FLOW_NS       70
`define DPMB_FLAG_GAP_NS   10
`define DPMB_SYNC_CYC      4
`define DPMB_CYC(ns)       ((((ns) * 1000) + `DPMB_CLK_PS - 1) / `DPMB_CLK_PS)
`define DPMB_OP_RAM_RD     2'h0
`define DPMB_OP_RAM_WR     2'h1
`define DPMB_OP_SEM_RD     2'h2
`define DPMB_OP_SEM_WR     2'h3
`endif

// >>> dpmb_sync.v
`timescale 1ns/1ps
`default_nettype none
module dpmb_sync #(
    parameter W = 1
) (
    input  wire         ref_clk,
    input  wire         rstn,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s1   <= {W{1'b0}};
            s2   <= {W{1'b0}};
            s3   <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            // Accept change once stages two and three agree
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule // dpmb_sync
`default_nettype wire

// >>> dpmb_port_master.v
`timescale 1ns/1ps
`default_nettype none
`include "dpmb_map.vh"
// Notes on behaviour
// RULE1 - Memory has 4K words of 9 bits, any location per port.
// RULE2 - Left write to FFF sets right mailbox flag low.
// RULE3 - Right read of FFF clears right mailbox flag.
// RULE4 - Right write to FFE sets left mailbox flag low.
// RULE5 - Left read of FFE clears left mailbox flag; message free-form.
// RULE6 - Device arbitrates matching addresses of both selected ports.
// RULE7 - Close accesses still give one winner, side not guaranteed.
// RULE8 - Loser sees hold signal low after match or late select.
// RULE9 - Role pin makes hold pins outputs as master, inputs as slave.
// RULE10 - Write happens only while select and write strobe both low.
// RULE11 - Data setup and hold referenced to rising edge ending write.
// RULE12 - Write strobe stays high whenever address changes.
// RULE13 - Read holds strobe high, asserts output enable and select.
// RULE14 - Semaphore access uses flag select, memory select stays high.
// RULE15 - Device floats data pins during write even with enable low.
// RULE16 - Reading a location being written waits flow-through delay.
// RULE17 - After semaphore write, deassert select for update gap first.
// RULE18 - Simultaneous semaphore requests give one side only.
// RULE19 - Semaphore write uses bit 0; zero requests, one releases.
// RULE20 - Pending request is granted when owner releases.
// RULE21 - Semaphore selected by low three address bits.
// RULE22 - Semaphore read drives value on all lines, latched.
module dpmb_port_master (
    input  wire                    ref_clk,
    input  wire                    rstn,
    input  wire                    reqValid,
    input  wire [1:0]              reqOp,
    input  wire [`DPMB_AW-1:0]     reqAddr,
    input  wire [`DPMB_DW-1:0]     reqData,
    output reg                     reqReady,
    output reg                     rspValid,
    output reg  [`DPMB_DW-1:0]     rspData,
    output reg                     rspContended,
    output reg                     mboxPending,
    output reg  [`DPMB_AW-1:0]     portAddr,
    output reg                     portSelect_n,
    output reg                     flagLatchSelect_n,
    output reg                     writeStrobe_n,
    output reg                     outputEnable_n,
    input  wire [`DPMB_DW-1:0]     portData_i,
    output reg  [`DPMB_DW-1:0]     portData_o,
    output reg                     portData_oe,
    input  wire                    contentionHold_n,
    input  wire                    mailboxFlag_n
);
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_SETUP = 5'h02;
    localparam [4:0] ST_STRB  = 5'h04;
    localparam [4:0] ST_HOLD  = 5'h08;
    localparam [4:0] ST_GAP   = 5'h10;
    localparam integer SETUP_NUM = `DPMB_CYC(`DPMB_SETUP_NS);
    localparam integer FLOW_NUM  = `DPMB_CYC(`DPMB_FLOW_NS) + `DPMB_SYNC_CYC;
    localparam integer WSTRB_NUM = `DPMB_CYC(`DPMB_STROBE_NS);
    localparam integer HOLD_NUM  = `DPMB_CYC(`DPMB_HOLD_NS);
    localparam integer GAP_NUM   = `DPMB_CYC(`DPMB_FLAG_GAP_NS);
    localparam [7:0] SETUP_CYC = SETUP_NUM[7:0];
    // Read strobe also covers the data synchroniser latency
    localparam [7:0] STRB_CYC  = FLOW_NUM[7:0];
    localparam [7:0] WSTRB_CYC = WSTRB_NUM[7:0];
    localparam [7:0] HOLD_CYC  = HOLD_NUM[7:0];
    localparam [7:0] GAP_CYC   = GAP_NUM[7:0];

    function isWrite;
        input [1:0] op;
        begin
            isWrite = (op == `DPMB_OP_RAM_WR) || (op == `DPMB_OP_SEM_WR);
        end
    endfunction

    function isSem;
        input [1:0] op;
        begin
            isSem = (op == `DPMB_OP_SEM_RD) || (op == `DPMB_OP_SEM_WR);
        end
    endfunction

    // Strobe length per operation
    function [7:0] strobeCycles;
        input [1:0] kind;
        begin
            strobeCycles = isWrite(kind) ? WSTRB_CYC : STRB_CYC;
        end
    endfunction

    wire [`DPMB_DW-1:0] dataSync;
    wire                holdAct;
    wire                flagAct;

    // Active-low pins inverted so the reset value reads as idle
    dpmb_sync #(.W(`DPMB_DW + 2)) uSync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .din     ({portData_i, ~contentionHold_n, ~mailboxFlag_n}),
        .dout    ({dataSync, holdAct, flagAct})
    );

    reg [4:0]          state;
    reg [7:0]          count;
    reg [1:0]          op;
    reg                sawHold;

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state             <= ST_IDLE;
            count             <= 8'h00;
            op                <= 2'h0;
            sawHold           <= 1'b0;
            reqReady          <= 1'b0;
            rspValid          <= 1'b0;
            rspData           <= {`DPMB_DW{1'b0}};
            rspContended      <= 1'b0;
            mboxPending       <= 1'b0;
            portAddr          <= {`DPMB_AW{1'b0}};
            portSelect_n      <= 1'b1;
            flagLatchSelect_n <= 1'b1;
            writeStrobe_n     <= 1'b1;
            outputEnable_n    <= 1'b1;
            portData_o        <= {`DPMB_DW{1'b0}};
            portData_oe       <= 1'b0;
        end else begin
            rspValid    <= 1'b0;
            mboxPending <= flagAct;
            case (state)
                ST_IDLE: begin
                    reqReady <= 1'b1;
                    if (reqValid && reqReady) begin
                        reqReady <= 1'b0;
                        op       <= reqOp;
                        sawHold  <= 1'b0;
                        // Semaphore address keeps only low bits
                        if (isSem(reqOp)) begin
                            portAddr <= {{(`DPMB_AW-`DPMB_SEM_AW){1'b0}},
                                         reqAddr[`DPMB_SEM_AW-1:0]}; // see RULE21
                        end else begin
                            portAddr <= reqAddr;
                        end
                        // Only bit 0 matters for semaphore writes
                        if (reqOp == `DPMB_OP_SEM_WR) begin
                            portData_o <= {{(`DPMB_DW-1){1'b0}}, reqData[0]}; // see RULE19
                        end else begin
                            portData_o <= reqData;
                        end
                        portData_oe <= isWrite(reqOp); // see RULE11
                        // Select asserted with strobe high while address settles
                        writeStrobe_n     <= 1'b1; // see RULE12
                        portSelect_n      <= isSem(reqOp); // see RULE14
                        flagLatchSelect_n <= ~isSem(reqOp); // see RULE14
                        outputEnable_n    <= isWrite(reqOp); // see RULE13
                        count <= SETUP_CYC;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (count > 8'h01) begin
                        count <= count - 8'h01;
                    end else begin
                        // Write only while select and strobe both low
                        writeStrobe_n <= ~isWrite(op); // see RULE10
                        count <= strobeCycles(op); // see RULE16
                        state <= ST_STRB;
                    end
                end
                ST_STRB: begin
                    if (holdAct) begin
                        sawHold <= 1'b1; // see RULE8
                    end
                    // Stretch while the arbiter holds this port off
                    if (holdAct) begin
                        count <= count; // see RULE6
                    end else if (count > 8'h01) begin
                        count <= count - 8'h01;
                    end else begin
                        if (!isWrite(op)) begin
                            rspData <= dataSync; // see RULE22
                        end
                        // Strobe rises first, data held after it
                        writeStrobe_n  <= 1'b1; // see RULE11
                        outputEnable_n <= 1'b1;
                        count <= HOLD_CYC;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (count > 8'h01) begin
                        count <= count - 8'h01;
                    end else begin
                        portSelect_n      <= 1'b1;
                        flagLatchSelect_n <= 1'b1;
                        portData_oe       <= 1'b0;
                        rspValid          <= 1'b1;
                        rspContended      <= sawHold; // see RULE7
                        // Semaphore write needs deselect gap before next read
                        count <= (op == `DPMB_OP_SEM_WR) ? GAP_CYC : 8'h01; // see RULE17
                        state <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (count > 8'h01) begin
                        count <= count - 8'h01;
                    end else begin
                        reqReady <= 1'b1;
                        state    <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // dpmb_port_master
`default_nettype wire

// >>> dpmb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dpmb_monitor (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        rspValid,
    input wire logic        mboxPending,
    input wire logic [11:0] portAddr,
    input wire logic        portSelect_n,
    input wire logic        flagLatchSelect_n,
    input wire logic        writeStrobe_n,
    input wire logic        outputEnable_n,
    input wire logic [8:0]  portData_o,
    input wire logic        portData_oe,
    input wire logic        mailboxFlag_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_addr_we_high:
        assert property ($changed(portAddr) |-> writeStrobe_n && $past(writeStrobe_n))
        else $error("address moved with strobe low");
    a_read_ctrl:
        assert property (!outputEnable_n |-> writeStrobe_n && !portData_oe)
        else $error("read without strobe high or with bus driven");
    a_one_select:
        assert property (!(!portSelect_n && !flagLatchSelect_n))
        else $error("both selects low");
    a_data_hold:
        assert property ($rose(writeStrobe_n) |-> portData_oe && $stable(portData_o))
        else $error("write data not held to strobe rise");
    a_flag_gap:
        assert property ($rose(flagLatchSelect_n) |=> flagLatchSelect_n)
        else $error("flag select gap too short");
    a_read_flow:
        assert property ($fell(outputEnable_n) |-> !outputEnable_n [*3])
        else $error("read strobe shorter than flow delay");
    a_rsp_pulse:
        assert property (rspValid |=> !rspValid)
        else $error("response longer than one cycle");
    a_we_in_select:
        assert property (!writeStrobe_n |-> !portSelect_n || !flagLatchSelect_n)
        else $error("write strobe low without a select");
    a_mbox_seen:
        assert property ($fell(mailboxFlag_n) |-> ##[1:6] mboxPending)
        else $error("mailbox flag not reported");
endmodule // dpmb_monitor
`default_nettype wire

// >>> dpmb_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpmb_dev_model (
    input  wire logic        ref_clk,
    input  wire logic [11:0] portAddr,
    input  wire logic        portSelect_n,
    input  wire logic        flagLatchSelect_n,
    input  wire logic        writeStrobe_n,
    input  wire logic        outputEnable_n,
    input  wire logic [8:0]  portData_o,
    input  wire logic        farMbox,
    input  wire logic [7:0]  farOwn,
    input  wire logic        holdIn_n,
    input  wire logic        farRdMbox,
    input  wire logic [7:0]  farPend,
    output wire logic [8:0]  portData_i,
    output wire logic        contentionHold_n,
    output var  logic        mailboxFlag_n,
    output var  logic        farFlag_n
);
    logic [8:0] mem [0:4095];
    logic [7:0] own = 8'h00;
    logic [7:0] farGot = 8'h00;
    logic [8:0] last = 9'h000;
    logic       wePrev = 1'b1;
    wire  [7:0] farHas = farOwn | farGot;
    wire  [2:0] semIdx = portAddr[2:0];
    wire        wrEnd = !wePrev && writeStrobe_n;
    wire        ramRd = !portSelect_n && !outputEnable_n && writeStrobe_n;
    wire        semRd = !flagLatchSelect_n && !outputEnable_n && writeStrobe_n;
    wire  [8:0] val = semRd ? {9{~own[semIdx]}} : mem[portAddr];
    assign portData_i = (ramRd || semRd) ? val : ~last;
    // Hold pin carries the far arbitration outcome
    assign contentionHold_n = holdIn_n;
    initial mailboxFlag_n = 1'b1;
    initial farFlag_n = 1'b1;
    always @(posedge ref_clk) begin
        wePrev <= writeStrobe_n;
        if (ramRd || semRd) last <= val;
        if (wrEnd && !portSelect_n) mem[portAddr] <= portData_o;
        if (wrEnd && !flagLatchSelect_n) begin
            own[semIdx] <= !portData_o[0] && !farHas[semIdx];
            if (portData_o[0] && own[semIdx] && farPend[semIdx])
                farGot[semIdx] <= 1'b1;
        end
        if (wrEnd && !portSelect_n && portAddr == 12'hfff) farFlag_n <= 1'b0;
        if (farRdMbox) farFlag_n <= 1'b1;
        if (ramRd && portAddr == 12'hffe) mailboxFlag_n <= 1'b1;
        if (farMbox) mailboxFlag_n <= 1'b0;
    end
endmodule // dpmb_dev_model
`default_nettype wire

// >>> dpmb_port_master_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dpmb_port_master_bench;
    logic ref_clk, rstn, reqValid, reqReady, rspValid, rspContended, mboxPending, portSelect_n;
    logic flagLatchSelect_n, writeStrobe_n, outputEnable_n, portData_oe, contentionHold_n;
    logic mailboxFlag_n, farMbox, holdIn_n;
    logic farRdMbox, farFlag_n;
    logic [1:0] reqOp;
    logic [11:0] reqAddr, portAddr;
    logic [8:0] reqData, rspData, portData_i, portData_o;
    logic [7:0] farOwn, farPend;
    int n_mismatch = 0;
    int comparisons = 0;
    dpmb_port_master dut_u (
        .ref_clk           (ref_clk),
        .rstn              (rstn),
        .reqValid          (reqValid),
        .reqOp             (reqOp),
        .reqAddr           (reqAddr),
        .reqData           (reqData),
        .reqReady          (reqReady),
        .rspValid          (rspValid),
        .rspData           (rspData),
        .rspContended      (rspContended),
        .mboxPending       (mboxPending),
        .portAddr          (portAddr),
        .portSelect_n      (portSelect_n),
        .flagLatchSelect_n (flagLatchSelect_n),
        .writeStrobe_n     (writeStrobe_n),
        .outputEnable_n    (outputEnable_n),
        .portData_i        (portData_i),
        .portData_o        (portData_o),
        .portData_oe       (portData_oe),
        .contentionHold_n  (contentionHold_n),
        .mailboxFlag_n     (mailboxFlag_n)
    );
    dpmb_dev_model dev_u (
        .ref_clk           (ref_clk),
        .portAddr          (portAddr),
        .portSelect_n      (portSelect_n),
        .flagLatchSelect_n (flagLatchSelect_n),
        .writeStrobe_n     (writeStrobe_n),
        .outputEnable_n    (outputEnable_n),
        .portData_o        (portData_o),
        .farMbox           (farMbox),
        .farOwn            (farOwn),
        .holdIn_n          (holdIn_n),
        .farRdMbox         (farRdMbox),
        .farPend           (farPend),
        .portData_i        (portData_i),
        .contentionHold_n  (contentionHold_n),
        .mailboxFlag_n     (mailboxFlag_n),
        .farFlag_n         (farFlag_n)
    );
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic access(input logic [1:0] op, input logic [11:0] a, input logic [8:0] d);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 200) begin @(posedge ref_clk); #1; n++; end
        {reqOp, reqAddr, reqData, reqValid} = {op, a, d, 1'b1};
        @(posedge ref_clk); #1;
        reqValid = 1'b0;
        while (rspValid !== 1'b1 && n < 200) begin @(posedge ref_clk); #1; n++; end
        if (n >= 200) chk(9'h000, 9'h1ff);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_ram;
        access(2'h1, 12'h000, 9'h1a5);
        access(2'h1, 12'hfff, 9'h05a);
        chk({8'h00, farFlag_n}, 9'h000);
        farRdMbox = 1'b1;
        @(posedge ref_clk); #1;
        farRdMbox = 1'b0;
        chk({8'h00, farFlag_n}, 9'h001);
        access(2'h0, 12'h000, 9'h000);
        chk(rspData, 9'h1a5);
        access(2'h0, 12'hfff, 9'h000);
        chk(rspData, 9'h05a);
        $display("test ram done");
    endtask
    task automatic t_mbox;
        farMbox = 1'b1;
        @(posedge ref_clk); #1;
        farMbox = 1'b0;
        repeat (8) @(posedge ref_clk); #1;
        chk({8'h00, mboxPending}, 9'h001);
        access(2'h0, 12'hffe, 9'h000);
        repeat (8) @(posedge ref_clk); #1;
        chk({8'h00, mboxPending}, 9'h000);
        $display("test mailbox done");
    endtask
    task automatic t_sem;
        access(2'h3, 12'h003, 9'h1fe);
        access(2'h2, 12'h003, 9'h000);
        chk(rspData, 9'h000);
        access(2'h3, 12'h005, 9'h000);
        access(2'h2, 12'h005, 9'h000);
        chk(rspData, 9'h1ff);
        farPend = 8'h08;
        access(2'h3, 12'h003, 9'h001);
        access(2'h2, 12'hffb, 9'h000);
        chk(rspData, 9'h1ff);
        chk(portAddr[11:3], 9'h000);
        access(2'h3, 12'h003, 9'h000);
        access(2'h2, 12'h003, 9'h000);
        chk(rspData, 9'h1ff);
        $display("test semaphore done");
    endtask
    task automatic t_hold;
        holdIn_n = 1'b0;
        repeat (6) @(posedge ref_clk); #1;
        fork
            begin repeat (12) @(posedge ref_clk); #1; holdIn_n = 1'b1; end
            access(2'h1, 12'h010, 9'h0c3);
        join
        chk({8'h00, rspContended}, 9'h001);
        access(2'h0, 12'h010, 9'h000);
        chk(rspData, 9'h0c3);
        chk({8'h00, rspContended}, 9'h000);
        $display("test hold done");
    endtask
    initial begin ref_clk = 1'b0; forever #12.5 ref_clk = ~ref_clk; end
    initial begin #100000; n_mismatch++; complete_run(); end
    initial begin
        {rstn, reqValid, reqOp, reqAddr, reqData, farMbox, holdIn_n} = 0;
        holdIn_n = 1'b1;
        farOwn = 8'h20;
        farPend = 8'h00;
        farRdMbox = 1'b0;
        repeat (16) @(posedge ref_clk); #1;
        rstn = 1'b1;
        t_ram();
        t_mbox();
        t_sem();
        t_hold();
        complete_run();
    end
endmodule // dpmb_port_master_bench
bind dpmb_port_master dpmb_monitor mon_u (
    .ref_clk           (ref_clk),
    .rstn              (rstn),
    .rspValid          (rspValid),
    .mboxPending       (mboxPending),
    .portAddr          (portAddr),
    .portSelect_n      (portSelect_n),
    .flagLatchSelect_n (flagLatchSelect_n),
    .writeStrobe_n     (writeStrobe_n),
    .outputEnable_n    (outputEnable_n),
    .portData_o        (portData_o),
    .portData_oe       (portData_oe),
    .mailboxFlag_n     (mailboxFlag_n)
);
`default_nettype wire
